// *** hdl/recorder_pkg.sv ***
/*
 * Shared constants for the fault recorder and indication reset logic:
 * register map, field layout, timing counts and record kinds.
 * Assumes a single 100 MHz system clock and a synchronous active-low reset.
 */
// Behaviour
// - Keep 25 records, overwrite oldest when full
// - Store values and timestamp on pickup or trip
// - Record also captures every lamp state
// - Minus key enters record view, newest first
// - Plus/minus step records, show parameter set
// - Replay: steady lamps flash, flashing flash briefly
// - Select key steps values of shown record
// - Unreset trip shows trip, hides measurements
// - Select+minus held 3 s erases memory, wait shown
// - Record on start end, trip, pickup end
// - Start record: start peaks, thermal, delta, duration
// - Pickup record: peak currents, thermal, time
// - Trip record: trip values, breaker failure time
// - Pickup flashes phase lamps, trip makes steady
// - Reset by key hold, input or host
// - Reset only when no function active
// - Select+plus held 3 s zeroes thermal memory
// - Changeover input selects alternate parameter set
// - Recorder trigger input makes a record
// - Running input holds the running state
// - Undelayed trip input trips and records at once
// - Delayed trip needs input for full delay
package recorder_pkg;
	localparam int DEPTH = 25;
	localparam int IDX_W = 5;
	localparam int NVAL = 8;
	localparam int VAL_W = 16;
	localparam int LAMP_W = 12;
	localparam int TS_W = 32;
	// Timing.
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int HOLD_MS = 3000;
	localparam int HOLD_TICKS = HOLD_MS * 1000 / TICK_US;
	localparam int BLINK_TICKS = 250;
	localparam int BRIEF_TICKS = 60;
	localparam int ERASE_TICKS = 100;
	localparam int EXT_DELAY_MS = 1000;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EXT_DELAY = 8'h08;
	localparam logic [7:0] REG_VIEW = 8'h0C;
	localparam logic [7:0] REG_VALUE = 8'h10;
	localparam logic [7:0] REG_LAMPS = 8'h14;
	localparam logic [7:0] REG_STAMP = 8'h18;
	localparam logic [7:0] REG_TIME = 8'h1C;
	// Control bits, write one to act.
	localparam int CTRL_RESET = 0;
	localparam int CTRL_ERASE = 1;
	// Status bits.
	localparam int ST_TRIP = 0;
	localparam int ST_RUN = 1;
	localparam int ST_PSET = 2;
	localparam int ST_VIEW = 3;
	localparam int ST_WAIT = 4;
	localparam int ST_BLANK = 5;
	localparam int ST_THZERO = 6;
	localparam int ST_COUNT = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [31:0] DELAY_RESET = 32'h0000_03E8;
	// Record kinds.
	typedef enum logic [1:0] {
		KIND_START = 2'b00,
		KIND_PICKUP = 2'b01,
		KIND_TRIP = 2'b10,
		KIND_EXT = 2'b11
	} kind_e;
endpackage : recorder_pkg

// *** hdl/hold_timer.sv ***
/*
 * Key hold detector; the millisecond tick comes from the divider in fault_recorder.
 * Assumes key inputs are already debounced and synchronous to sys_clk.
 */
`timescale 1ns/1ps
module hold_timer import recorder_pkg::*; #(
	parameter int HOLD = HOLD_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [2:0] keys,
	output logic [2:0] fired
);
	logic [2:0] last_q;
	logic [15:0] cnt_q;
	logic done_q;

	// Count ticks while a combination is held; a change restarts the count.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			last_q <= 3'h0;
			cnt_q <= 16'h0000;
			done_q <= 1'b0;
			fired <= 3'h0;
		end else begin
			last_q <= keys;
			fired <= 3'h0;
			if (keys != last_q || keys == 3'h0) begin
				cnt_q <= 16'h0000;
				done_q <= 1'b0;
			end else if (tick && !done_q) begin
				if (cnt_q == 16'(HOLD - 1)) begin
					done_q <= 1'b1; // Fires once per hold.
					fired <= keys;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule : hold_timer

// *** hdl/record_store.sv ***
/*
 * Circular store of fault records in flip-flops, newest first on read.
 * Assumes the writer presents a full record in the cycle of wr.
 */
`timescale 1ns/1ps
module record_store import recorder_pkg::*; #(
	parameter int N = DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wr,
	input wire logic clr,
	input wire logic [NVAL*VAL_W-1:0] wr_vals,
	input wire logic [LAMP_W-1:0] wr_lamps,
	input wire logic [TS_W-1:0] wr_stamp,
	input wire logic [3:0] wr_info,
	input wire logic [IDX_W-1:0] rd_age,
	output logic [NVAL*VAL_W-1:0] rd_vals,
	output logic [LAMP_W-1:0] rd_lamps,
	output logic [TS_W-1:0] rd_stamp,
	output logic [3:0] rd_info,
	output logic [IDX_W-1:0] count
);
	logic [NVAL*VAL_W-1:0] vals_q [N];
	logic [LAMP_W-1:0] lamps_q [N];
	logic [TS_W-1:0] stamp_q [N];
	logic [3:0] info_q [N];
	logic [IDX_W-1:0] head_q;
	logic [IDX_W-1:0] slot;

	// Age 0 is the newest; the slot wraps backward from the head.
	assign slot = (head_q > rd_age) ? head_q - rd_age - 1'b1
		: IDX_W'(N) - (rd_age - head_q) - 1'b1;
	assign rd_vals = vals_q[slot];
	assign rd_lamps = lamps_q[slot];
	assign rd_stamp = stamp_q[slot];
	assign rd_info = info_q[slot];

	// Write pointer and fill count; writing past full reuses the oldest slot.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || clr) begin
			head_q <= '0;
			count <= '0;
		end else if (wr) begin
			head_q <= (head_q == IDX_W'(N - 1)) ? '0 : head_q + 1'b1;
			if (count != IDX_W'(N)) count <= count + 1'b1;
		end
	end

	// Payload storage; no reset, contents are only read below count.
	always_ff @(posedge sys_clk) begin
		if (wr) begin
			vals_q[head_q] <= wr_vals;
			lamps_q[head_q] <= wr_lamps;
			stamp_q[head_q] <= wr_stamp;
			info_q[head_q] <= wr_info;
		end
	end
endmodule : record_store

// *** hdl/fault_recorder.sv ***
/*
 * Fault recorder, record browser, lamp driver and indication reset logic
 * with an AXI4-Lite register slave.
 * Assumes measured values, element pickup and trip flags arrive from the
 * protection core synchronous to sys_clk, and keys are debounced.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module fault_recorder import recorder_pkg::*; #(
	parameter int HOLD = HOLD_TICKS,
	parameter int TICK = TICK_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	// AXI4-Lite slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Front panel keys.
	input wire logic key_plus,
	input wire logic key_minus,
	input wire logic key_select,
	// Control inputs.
	input wire logic in_pset_change,
	input wire logic in_rec_trigger,
	input wire logic in_motor_running,
	input wire logic in_trip_now,
	input wire logic in_trip_delayed,
	input wire logic in_ext_reset,
	// Protection core state.
	input wire logic [5:0] phase_pickup,
	input wire logic [5:0] func_pickup,
	input wire logic func_trip,
	input wire logic start_end,
	input wire logic current_running,
	input wire logic [NVAL*VAL_W-1:0] meas_vals,
	// Outputs.
	output logic [LAMP_W-1:0] lamps,
	output logic trip_relay,
	output logic running,
	output logic pset_alt,
	output logic show_trip,
	output logic show_wait,
	output logic view_active,
	output logic thermal_zero
);
	typedef enum logic [2:0] {
		V_NORMAL = 3'b001,
		V_RECORD = 3'b010,
		V_ERASE = 3'b100
	} view_e;

	view_e view_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [2:0] fired;
	logic [2:0] keys;
	logic [2:0] keys_q;
	logic [IDX_W-1:0] age_q;
	logic [2:0] val_sel_q;
	logic [IDX_W-1:0] count;
	logic [NVAL*VAL_W-1:0] rd_vals;
	logic [LAMP_W-1:0] rd_lamps;
	logic [TS_W-1:0] rd_stamp;
	logic [3:0] rd_info;
	logic [TS_W-1:0] stamp_q;
	logic [31:0] ext_delay_q;
	logic [31:0] ext_cnt_q;
	logic ext_trip_q;
	logic trip_latch_q;
	logic pickup_q;
	logic rec_trig_q;
	logic rec_wr;
	kind_e rec_kind;
	logic [15:0] erase_cnt_q;
	logic [8:0] blink_cnt_q;
	logic blink_q;
	logic brief_q;
	logic host_reset_q;
	logic host_erase_q;
	logic reset_req;
	logic any_active;
	logic [11:0] live_lamps;
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;

	// True when a key press newly appears.
	function automatic logic rose(input logic now, input logic was);
		return now && !was;
	endfunction : rose

	// Millisecond tick divider.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 32'(TICK - 1));
			tick_cnt_q <= (tick_cnt_q == 32'(TICK - 1)) ? 32'h0000_0000 : tick_cnt_q + 1;
		end
	end

	assign keys = {key_select, key_plus, key_minus};

	hold_timer #(.HOLD(HOLD)) u_hold (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick(tick_q),
		.keys(keys),
		.fired(fired)
	);

	// Delayed external trip qualifies only over an unbroken delay.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_cnt_q <= 32'h0000_0000;
			ext_trip_q <= 1'b0;
		end else if (!in_trip_delayed) begin
			ext_cnt_q <= 32'h0000_0000; // A drop restarts it.
			ext_trip_q <= 1'b0;
		end else if (tick_q && ext_cnt_q < ext_delay_q) begin
			ext_cnt_q <= ext_cnt_q + 1;
		end else if (ext_cnt_q >= ext_delay_q) begin
			ext_trip_q <= 1'b1;
		end
	end

	assign any_active = func_trip || in_trip_now || ext_trip_q || (|func_pickup);
	assign reset_req = (fired == 3'b100) || in_ext_reset || host_reset_q;

	// Trip latch and relay; reset is refused while a function is active.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trip_latch_q <= 1'b0;
			trip_relay <= 1'b0;
		end else begin
			if (func_trip || in_trip_now || ext_trip_q) begin
				trip_latch_q <= 1'b1;
				trip_relay <= 1'b1;
			end else if (reset_req && !any_active) begin
				trip_latch_q <= 1'b0;
				trip_relay <= 1'b0;
			end
		end
	end

	// Record triggers: start end, trip edge, pickup end, external input.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pickup_q <= 1'b0;
			rec_trig_q <= 1'b0;
		end else begin
			pickup_q <= |func_pickup;
			rec_trig_q <= in_rec_trigger;
		end
	end

	always_comb begin
		rec_wr = 1'b1;
		rec_kind = KIND_TRIP;
		if ((func_trip || in_trip_now || ext_trip_q) && !trip_latch_q) begin
			rec_kind = KIND_TRIP;
		end else if (start_end) begin
			rec_kind = KIND_START;
		end else if (pickup_q && !(|func_pickup) && running && !trip_latch_q) begin
			rec_kind = KIND_PICKUP;
		end else if (rose(in_rec_trigger, rec_trig_q)) begin
			rec_kind = KIND_EXT;
		end else begin
			rec_wr = 1'b0;
		end
	end

	// Timestamp counts milliseconds since reset.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) stamp_q <= 32'h0000_0000;
		else if (tick_q) stamp_q <= stamp_q + 1;
	end

	record_store #(.N(DEPTH)) u_store (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr(rec_wr && view_q != V_ERASE),
		.clr(view_q == V_ERASE && erase_cnt_q == 16'h0000),
		.wr_vals(meas_vals),
		.wr_lamps(live_lamps),
		.wr_stamp(stamp_q),
		.wr_info({in_pset_change, 1'b0, rec_kind}),
		.rd_age(age_q),
		.rd_vals(rd_vals),
		.rd_lamps(rd_lamps),
		.rd_stamp(rd_stamp),
		.rd_info(rd_info),
		.count(count)
	);

	// Browser view state and record / value selection.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			view_q <= V_NORMAL;
			keys_q <= 3'h0;
			age_q <= '0;
			val_sel_q <= 3'h0;
			erase_cnt_q <= 16'h0000;
		end else begin
			keys_q <= keys;
			case (view_q)
				V_NORMAL: begin
					if (fired == 3'b101 || host_erase_q) begin
						view_q <= V_ERASE;
						erase_cnt_q <= 16'(ERASE_TICKS);
					end else if (rose(key_minus, keys_q[0]) && !key_select) begin
						view_q <= V_RECORD; // Newest is shown first.
						age_q <= '0;
						val_sel_q <= 3'h0;
					end
				end
				V_RECORD: begin
					if (fired == 3'b101 || host_erase_q) begin
						view_q <= V_ERASE;
						erase_cnt_q <= 16'(ERASE_TICKS);
					end else if (keys == 3'b000 && count == '0) begin
						view_q <= V_NORMAL;
					end else if (rose(key_minus, keys_q[0]) && !key_select) begin
						if (age_q + 1'b1 < count) age_q <= age_q + 1'b1;
						val_sel_q <= 3'h0;
					end else if (rose(key_plus, keys_q[1]) && !key_select) begin
						if (age_q == '0) view_q <= V_NORMAL;
						else age_q <= age_q - 1'b1;
						val_sel_q <= 3'h0;
					end else if (keys == 3'b100 && keys_q == 3'b000) begin
						val_sel_q <= val_sel_q + 3'h1;
					end
				end
				V_ERASE: begin
					if (erase_cnt_q == 16'h0000) view_q <= V_NORMAL;
					else if (tick_q) erase_cnt_q <= erase_cnt_q - 16'h0001;
				end
				default: view_q <= V_NORMAL;
			endcase
		end
	end

	// Blink clocks: a slow flash and a short burst for past pickups.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			blink_cnt_q <= 9'h000;
			blink_q <= 1'b0;
			brief_q <= 1'b0;
		end else if (tick_q) begin
			if (blink_cnt_q == 9'(BLINK_TICKS - 1)) begin
				blink_cnt_q <= 9'h000;
				blink_q <= !blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 9'h001;
			end
			brief_q <= blink_q && blink_cnt_q < 9'(BRIEF_TICKS);
		end
	end

	// Live lamps: upper half steady phase lamps once tripped, lower half flashing pickup lamps.
	assign live_lamps = trip_latch_q ? {phase_pickup, func_pickup}
		: {6'h00, phase_pickup | func_pickup};

	// Lamp driver.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lamps <= '0;
		end else if (view_q == V_RECORD) begin
			lamps <= ({6'h00, rd_lamps[11:6]} & {LAMP_W{blink_q}})
				| ({6'h00, rd_lamps[5:0]} & {LAMP_W{brief_q}});
		end else begin
			lamps <= {live_lamps[11:6] | func_pickup, // Function lamp lights.
				live_lamps[5:0] & {6{blink_q}}};
		end
	end

	// Status outputs.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			running <= 1'b0;
			pset_alt <= 1'b0;
			show_trip <= 1'b0;
			show_wait <= 1'b0;
			view_active <= 1'b0;
			thermal_zero <= 1'b0;
		end else begin
			running <= current_running || in_motor_running;
			pset_alt <= (view_q == V_RECORD) ? rd_info[3] : in_pset_change;
			show_trip <= trip_latch_q; // Measurements blanked in normal view only.
			show_wait <= view_q == V_ERASE;
			view_active <= view_q == V_RECORD;
			thermal_zero <= fired == 3'b110;
		end
	end

	// AXI4-Lite write channel: address and data taken in either order.
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ext_delay_q <= DELAY_RESET;
			host_reset_q <= 1'b0;
			host_erase_q <= 1'b0;
		end else begin
			host_reset_q <= 1'b0;
			host_erase_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (aw_q && w_q) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				case (awaddr_q)
					REG_CTRL: begin
						host_reset_q <= wdata_q[CTRL_RESET];
						host_erase_q <= wdata_q[CTRL_ERASE];
					end
					REG_EXT_DELAY: ext_delay_q <= wdata_q;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel, one cycle after the address is taken.
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL: s_axi_rdata <= 32'h0000_0000;
				REG_STATUS: s_axi_rdata <= {19'h0_0000, count, 1'b0, thermal_zero,
					trip_latch_q && view_q == V_NORMAL, show_wait, view_active,
					pset_alt, running, show_trip};
				REG_EXT_DELAY: s_axi_rdata <= ext_delay_q;
				REG_VIEW: s_axi_rdata <= {20'h0_0000, rd_info, val_sel_q, age_q + 1'b1};
				REG_VALUE: s_axi_rdata <= {16'h0000, rd_vals[val_sel_q*VAL_W +: VAL_W]};
				REG_LAMPS: s_axi_rdata <= {20'h0_0000, rd_lamps};
				REG_STAMP: s_axi_rdata <= rd_stamp;
				REG_TIME: s_axi_rdata <= stamp_q;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : fault_recorder

// *** tb/fault_recorder_monitor.sv ***
/* Checker for the fault recorder ports: trip, reset, input and bus timing.
   Assumes it is bound onto fault_recorder with one clock, sys_clk. */
`timescale 1ns/1ps
module fault_recorder_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic in_trip_now,
	input wire logic in_trip_delayed,
	input wire logic func_trip,
	input wire logic [5:0] func_pickup,
	input wire logic in_pset_change,
	input wire logic in_motor_running,
	input wire logic view_active,
	input wire logic pset_alt,
	input wire logic running,
	input wire logic trip_relay,
	input wire logic show_trip,
	input wire logic thermal_zero
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// A trip input is followed by the relay, then by the indication.
	sequence s_tripped;
		in_trip_now ##1 trip_relay;
	endsequence
	property p_trip_now; in_trip_now |=> trip_relay; endproperty
	// The indication follows the latch one cycle after the relay.
	property p_show; s_tripped |=> show_trip; endproperty
	// A reset must not clear while the undelayed trip input, a protection trip or a pickup is active.
	property p_keep;
		trip_relay && (in_trip_now || func_trip || func_pickup != 6'h00) |=> trip_relay;
	endproperty
	// A fresh delayed input may never trip in its first cycle.
	property p_delay;
		$rose(in_trip_delayed) && !trip_relay && !in_trip_now && !func_trip |=> !trip_relay;
	endproperty
	property p_run; in_motor_running |=> running; endproperty
	property p_pset; in_pset_change && !view_active |=> pset_alt || view_active; endproperty
	property p_tz; thermal_zero |=> !thermal_zero; endproperty
	property p_bstand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_busy; s_axi_rvalid |-> !s_axi_arready ##0 (!s_axi_bvalid || !s_axi_awready); endproperty
	a_trip_now: assert property (p_trip_now) else $error("trip input ignored");
	a_show: assert property (p_show) else $error("trip not indicated");
	a_keep: assert property (p_keep) else $error("trip cleared while active");
	a_delay: assert property (p_delay) else $error("delayed trip too early");
	a_run: assert property (p_run) else $error("running not held");
	a_pset: assert property (p_pset) else $error("alternate set not used");
	a_tz: assert property (p_tz) else $error("thermal zero repeated");
	a_bstand: assert property (p_bstand) else $error("write answer dropped");
	a_busy: assert property (p_busy) else $error("request taken while busy");
endmodule : fault_recorder_monitor

bind fault_recorder fault_recorder_monitor fault_recorder_monitor_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .in_trip_now(in_trip_now),
	.in_trip_delayed(in_trip_delayed), .func_trip(func_trip), .func_pickup(func_pickup),
	.in_pset_change(in_pset_change), .in_motor_running(in_motor_running),
	.view_active(view_active), .pset_alt(pset_alt), .running(running),
	.trip_relay(trip_relay), .show_trip(show_trip), .thermal_zero(thermal_zero));

// *** tb/panel_model.sv ***
/* Front panel model: turns a key combination request into key levels.
   Assumes the bench changes the request just after a rising edge. */
`timescale 1ns/1ps
module panel_model (
	input wire logic sys_clk,
	input wire logic [2:0] combo,
	output logic key_plus,
	output logic key_minus,
	output logic key_select
);
	// Keys are registered so they change only just after an edge, as a real
	// debounced panel would; holding combo holds the keys.
	always_ff @(posedge sys_clk) begin
		key_select <= combo[2];
		key_minus <= combo[1];
		key_plus <= combo[0];
	end
endmodule : panel_model

// *** tb/fault_recorder_tb.sv ***
/* Self-checking bench for the fault recorder: bus, keys, trips, records.
   Assumes short HOLD and TICK values so key holds take a few cycles. */
`timescale 1ns/1ps
module fault_recorder_tb import recorder_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] combo = 3'h0;
	logic key_plus, key_minus, key_select;
	logic in_pset_change = 1'b0, in_rec_trigger = 1'b0, in_motor_running = 1'b0;
	logic in_trip_now = 1'b0, in_trip_delayed = 1'b0, in_ext_reset = 1'b0;
	logic func_trip = 1'b0, start_end = 1'b0;
	logic [5:0] func_pickup = 6'h00;
	logic [LAMP_W-1:0] lamps;
	logic trip_relay, running, pset_alt, show_trip, show_wait, view_active, thermal_zero;
	int err_count = 0, checked = 0, tz_seen = 0, wait_seen = 0;

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// Count pulses here so short ones are never missed between checks.
	always @(posedge sys_clk) begin
		if (thermal_zero === 1'b1) tz_seen++;
		if (show_wait === 1'b1) wait_seen++;
	end

	fault_recorder #(.HOLD(4), .TICK(4)) fault_recorder_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .key_plus(key_plus), .key_minus(key_minus),
		.key_select(key_select), .in_pset_change(in_pset_change),
		.in_rec_trigger(in_rec_trigger), .in_motor_running(in_motor_running),
		.in_trip_now(in_trip_now), .in_trip_delayed(in_trip_delayed),
		.in_ext_reset(in_ext_reset), .phase_pickup(6'h00), .func_pickup(func_pickup),
		.func_trip(func_trip), .start_end(start_end), .current_running(1'b0),
		.meas_vals({8{16'h1234}}), .lamps(lamps), .trip_relay(trip_relay),
		.running(running), .pset_alt(pset_alt), .show_trip(show_trip),
		.show_wait(show_wait), .view_active(view_active), .thermal_zero(thermal_zero));
	panel_model panel_model_i (.sys_clk(sys_clk), .combo(combo), .key_plus(key_plus),
		.key_minus(key_minus), .key_select(key_select));

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Write: address and data offered together, each dropped once taken.
	task automatic axi_w(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
	endtask : axi_w
	task automatic axi_r(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_r
	task automatic press(input logic [2:0] c, input int n);
		@(posedge sys_clk);
		combo <= c;
		cyc(n);
		combo <= 3'h0;
		cyc(4);
	endtask : press
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	// Watchdog: the sequence takes a few thousand cycles at most.
	initial begin
		#200_000;
		err_count++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		cyc(2);
		chk({lamps, trip_relay, running, pset_alt, show_trip, show_wait, view_active}, 0);
		axi_r(REG_EXT_DELAY); chk(rd, DELAY_RESET);
		axi_r(8'h40); chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		axi_r(REG_STATUS); chk(rd, 32'h0000_0000);
		in_pset_change <= 1'b1;
		in_motor_running <= 1'b1;
		cyc(3); chk({pset_alt, running}, 2'b11);
		in_pset_change <= 1'b0;
		in_motor_running <= 1'b0;
		// Immediate trip, then resets from the input while active and idle.
		in_trip_now <= 1'b1;
		cyc(3); chk({trip_relay, show_trip}, 2'b11);
		in_ext_reset <= 1'b1;
		cyc(3); chk(trip_relay, 1'b1);
		in_ext_reset <= 1'b0;
		in_trip_now <= 1'b0;
		cyc(2);
		in_ext_reset <= 1'b1;
		cyc(3); chk(trip_relay, 1'b0);
		in_ext_reset <= 1'b0;
		axi_r(REG_STATUS); chk(rd, 32'h0000_0100);
		// Protection trip cleared by the host, then an immediate input trip by a key hold.
		func_trip <= 1'b1;
		cyc(2); func_trip <= 1'b0;
		cyc(2); chk(trip_relay, 1'b1);
		axi_w(REG_CTRL, 32'h0000_0001);
		cyc(3); chk(trip_relay, 1'b0);
		in_trip_now <= 1'b1;
		cyc(2); in_trip_now <= 1'b0;
		press(3'b100, 40); chk(trip_relay, 1'b0);
		// Combo bits are select, minus, plus: select+plus zeroes the thermal image.
		press(3'b101, 40); chk(tz_seen, 1);
		// Delayed trip: short pulses never qualify, a long one does.
		axi_w(REG_EXT_DELAY, 32'h0000_0003);
		repeat (2) begin
			in_trip_delayed <= 1'b1;
			cyc(6); in_trip_delayed <= 1'b0;
			cyc(2);
		end
		chk(trip_relay, 1'b0);
		in_trip_delayed <= 1'b1;
		cyc(40); chk(trip_relay, 1'b1);
		in_trip_delayed <= 0;
		in_ext_reset <= 1'b1;
		cyc(3); in_ext_reset <= 1'b0;
		axi_r(REG_EXT_DELAY); chk(rd, 32'h0000_0003);
		// Pickup while running: function lamp lights, its end makes a record.
		in_motor_running <= 1'b1;
		func_pickup <= 6'h01;
		cyc(3); chk(lamps & 12'hFC0, 12'h040);
		func_pickup <= 6'h00;
		cyc(3); in_motor_running <= 1'b0;
		axi_r(REG_STATUS); chk(rd, 32'h0000_0500);
		// Overfill the store; the newest record is an external one.
		start_end <= 1'b1;
		cyc(1); start_end <= 1'b0;
		repeat (26) begin
			in_rec_trigger <= 1'b1;
			cyc(2); in_rec_trigger <= 1'b0;
			cyc(2);
		end
		axi_r(REG_STATUS); chk(rd, 32'h0000_1900);
		press(3'b010, 3); axi_r(REG_VIEW); chk(rd & 32'h0000_0F1F, 32'h0000_0301);
		chk(view_active, 1'b1);
		press(3'b010, 3); axi_r(REG_VIEW); chk(rd & 32'h0000_00FF, 32'h0000_0002);
		press(3'b100, 3); axi_r(REG_VIEW); chk(rd & 32'h0000_00FF, 32'h0000_0022);
		press(3'b001, 3); axi_r(REG_VIEW); chk(rd & 32'h0000_001F, 32'h0000_0001);
		press(3'b001, 3); chk(view_active, 1'b0);
		// Erase by key hold: the wait indication shows, then the store is empty.
		press(3'b110, 40);
		cyc(500); chk(wait_seen != 0, 1'b1);
		axi_r(REG_STATUS); chk(rd & 32'h0000_1F00, 32'h0000_0000);
		conclude();
	end
endmodule : fault_recorder_tb
